// File: hw/mix_core.sv
// Package of constants and the instruction decode and execute top module.
// Function
// - Return with literal loads W, pops, two cycles.
// - Rotate left through carry, only carry changes.
// - Rotate right through carry, only carry changes.
// - Destination bit zero writes W, one writes file.
// - Sleep clears power-down, sets time-out, clears watchdog.
// - Sleep stops the oscillator until wake.
// - Literal minus W into W, updates C, DC, Z.
// - Carry set when no borrow, cleared on borrow.
// - File minus W, steered, wraps modulo 256.
// - Direction load copies W, ports 5, 6 only.
// - Direction bit one makes pin an input.
// - XOR literal into W, only zero flag.
// - XOR file, steered, only zero flag.
//
// Implementation choices: the address map and the address-and-strobe port.
package mix_pkg;
  // Instruction word layout.
  localparam int INSTR_W = 14;
  localparam int CLASS_HI = 13;
  localparam int CLASS_LO = 12;
  localparam int OPC_HI = 11;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int FADDR_W = 7;
  // Low bit of the file address field.
  localparam int FADDR_LSB = 0;
  localparam int DATA_W = 8;
  // Class field values.
  localparam logic [1:0] CLASS_FILE = 2'h0;
  localparam logic [1:0] CLASS_LIT = 2'h3;
  // Byte-oriented file opcodes.
  localparam logic [3:0] OPC_SUB_FILE = 4'h2;
  localparam logic [3:0] OPC_XOR_FILE = 4'h6;
  localparam logic [3:0] OPC_ROT_RIGHT = 4'hc;
  localparam logic [3:0] OPC_ROT_LEFT = 4'hd;
  localparam logic [3:0] OPC_SWAP = 4'he;
  // Literal opcodes; low bits marked don't-care are masked by the decoder.
  localparam logic [3:0] OPC_RET_LIT = 4'h1;
  localparam logic [3:0] OPC_XOR_LIT = 4'ha;
  localparam logic [2:0] OPC_SUB_LIT = 3'h6;
  // Whole-word instructions; the direction load matches only bits 13 to 3.
  localparam logic [13:0] INSTR_RETURN = 14'h0008;
  localparam logic [13:0] INSTR_SLEEP = 14'h0063;
  localparam logic [10:0] INSTR_DIR_LOAD = 11'h00c;
  localparam logic [2:0] DIR_PORT_A = 3'h5;
  localparam logic [2:0] DIR_PORT_B = 3'h6;
  // Register map of the software port.
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_WREG = 8'h7f;
  localparam logic [7:0] ADDR_DIR_A = 8'h85;
  localparam logic [7:0] ADDR_DIR_B = 8'h86;
  // Status register bit positions.
  localparam int ST_CARRY = 0;
  localparam int ST_DC = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  // Reset values.
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] WREG_RESET = 8'h00;
  // Operations handed to the arithmetic unit.
  typedef enum logic [2:0] {
    MIX_OP_PASS = 3'h0,
    MIX_OP_SUB = 3'h1,
    MIX_OP_XOR = 3'h2,
    MIX_OP_RL = 3'h3,
    MIX_OP_RR = 3'h4,
    MIX_OP_SWAP = 3'h5
  } mix_op_e;
  // Sequencer states; every transition to or from run flips a single bit.
  typedef enum logic [1:0] {
    MIX_ST_RUN = 2'h0,
    MIX_ST_DISCARD = 2'h1,
    MIX_ST_SLEEP = 2'h2
  } mix_state_e;
endpackage

// Decodes and executes the return, rotate, sleep, subtract, swap,
// direction-load and exclusive-OR instructions of the core.
module mix_core #(
  parameter int PORT_A_W = 5,
  parameter int PORT_B_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  input wire logic [12:0] stack_top,
  input wire logic wake,
  input wire logic [7:0] file_rdata,
  output logic [6:0] file_raddr,
  output logic file_we,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic pc_load,
  output logic [12:0] pc_value,
  output logic stack_pop,
  output logic fetch_discard,
  output logic sleep_req,
  output logic watchdog_clear,
  output logic busy,
  output logic [7:0] w_out,
  output logic [PORT_A_W-1:0] port_a_oe,
  output logic [PORT_B_W-1:0] port_b_oe,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata
);
  // Working register and status flags.
  logic [7:0] w_q, w_d;
  logic carry_q, carry_d;
  logic dc_q, dc_d;
  logic zero_q, zero_d;
  logic power_down_flag_q, power_down_flag_d;
  logic time_out_flag_q, time_out_flag_d;
  // Port direction registers, one bit per pin.
  logic [PORT_A_W-1:0] dir_a_q, dir_a_d;
  logic [PORT_B_W-1:0] dir_b_q, dir_b_d;
  // Sequencer state.
  mix_pkg::mix_state_e state_q, state_d;
  // Registered side-effect outputs.
  logic file_we_q;
  logic [6:0] file_waddr_q;
  logic [7:0] file_wdata_q;
  logic pc_load_q;
  logic [12:0] pc_value_q;
  logic watchdog_clear_q;
  logic [7:0] reg_rdata_q;

  // Field extraction from the single instruction word.
  wire [1:0] cls = instr[mix_pkg::CLASS_HI:mix_pkg::CLASS_LO];
  wire [3:0] opc = instr[mix_pkg::OPC_HI:mix_pkg::OPC_LO];
  wire dest_file = instr[mix_pkg::DEST_BIT];
  wire [7:0] literal = instr[mix_pkg::DATA_W-1:0];
  wire [2:0] port_sel = instr[2:0];

  // An instruction is only executed while running.
  wire exec = instr_valid && (state_q == mix_pkg::MIX_ST_RUN);
  wire is_file = exec && (cls == mix_pkg::CLASS_FILE);
  wire is_lit = exec && (cls == mix_pkg::CLASS_LIT);

  // Individual instruction decodes.
  wire dec_ret_lit = is_lit && (opc[3:2] == mix_pkg::OPC_RET_LIT[1:0]);
  wire dec_xor_lit = is_lit && (opc == mix_pkg::OPC_XOR_LIT);
  wire dec_sub_lit = is_lit && (opc[3:1] == mix_pkg::OPC_SUB_LIT);
  wire dec_sub_file = is_file && (opc == mix_pkg::OPC_SUB_FILE);
  wire dec_xor_file = is_file && (opc == mix_pkg::OPC_XOR_FILE);
  wire dec_rot_left = is_file && (opc == mix_pkg::OPC_ROT_LEFT);
  wire dec_rot_right = is_file && (opc == mix_pkg::OPC_ROT_RIGHT);
  wire dec_swap = is_file && (opc == mix_pkg::OPC_SWAP);
  wire dec_return = exec && (instr == mix_pkg::INSTR_RETURN);
  wire dec_sleep = exec && (instr == mix_pkg::INSTR_SLEEP);
  wire dec_dir = exec && (instr[13:3] == mix_pkg::INSTR_DIR_LOAD);
  // Only the two implemented ports accept a direction load.
  wire dir_load_a = dec_dir && (port_sel == mix_pkg::DIR_PORT_A);
  wire dir_load_b = dec_dir && (port_sel == mix_pkg::DIR_PORT_B);

  // Groups that share datapath handling.
  wire file_op = dec_sub_file | dec_xor_file | dec_rot_left | dec_rot_right | dec_swap;
  wire lit_op = dec_sub_lit | dec_xor_lit;
  wire pop_op = dec_ret_lit | dec_return;

  // Operation select for the arithmetic unit.
  mix_pkg::mix_op_e alu_op;
  assign alu_op = (dec_sub_file | dec_sub_lit) ? mix_pkg::MIX_OP_SUB :
                  (dec_xor_file | dec_xor_lit) ? mix_pkg::MIX_OP_XOR :
                  dec_rot_left ? mix_pkg::MIX_OP_RL :
                  dec_rot_right ? mix_pkg::MIX_OP_RR :
                  dec_swap ? mix_pkg::MIX_OP_SWAP : mix_pkg::MIX_OP_PASS;

  // The minuend is the literal for literal forms and the file otherwise.
  wire [7:0] alu_a = is_lit ? literal : file_rdata;
  wire [7:0] alu_res;
  wire alu_c, alu_dc, alu_z;
  wire upd_c, upd_dc, upd_z;

  // Arithmetic and logic unit shared by every data instruction.
  mix_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .w(w_q),
    .carry_in(carry_q),
    .result(alu_res),
    .carry_out(alu_c),
    .dc_out(alu_dc),
    .zero_out(alu_z),
    .upd_c(upd_c),
    .upd_dc(upd_dc),
    .upd_z(upd_z)
  );

  // Where the result goes.
  wire to_w = lit_op | (file_op & ~dest_file);
  wire to_file = file_op & dest_file;
  wire any_flag_op = file_op | lit_op;

  // Software access decode for the register port.
  wire sw_wr_a = reg_we && (reg_addr == mix_pkg::ADDR_DIR_A);
  wire sw_wr_b = reg_we && (reg_addr == mix_pkg::ADDR_DIR_B);
  wire sw_wr_w = reg_we && (reg_addr == mix_pkg::ADDR_WREG);
  wire [7:0] status_view = {3'h0, time_out_flag_q, power_down_flag_q, zero_q, dc_q, carry_q};
  wire [7:0] dir_a_view = 8'(dir_a_q);
  wire [7:0] dir_b_view = 8'(dir_b_q);

  // Read mux; unmapped addresses read zero.
  wire [7:0] rd_mux = (reg_addr == mix_pkg::ADDR_STATUS) ? status_view :
                      (reg_addr == mix_pkg::ADDR_WREG) ? w_q :
                      (reg_addr == mix_pkg::ADDR_DIR_A) ? dir_a_view :
                      (reg_addr == mix_pkg::ADDR_DIR_B) ? dir_b_view : 8'h00;

  // Working register: instruction results win over a software write.
  always_comb begin
    w_d = w_q;
    if (sw_wr_w) begin
      w_d = reg_wdata;
    end
    if (dec_ret_lit) begin
      w_d = literal;
    end else if (to_w) begin
      w_d = alu_res;
    end
  end

  // Flag updates; each instruction only touches the flags it owns.
  always_comb begin
    carry_d = carry_q;
    dc_d = dc_q;
    zero_d = zero_q;
    if (any_flag_op && upd_c) begin
      carry_d = alu_c;
    end
    if (any_flag_op && upd_dc) begin
      dc_d = alu_dc;
    end
    if (any_flag_op && upd_z) begin
      zero_d = alu_z;
    end
  end

  // Power-down and time-out flags follow the sleep instruction.
  always_comb begin
    power_down_flag_d = power_down_flag_q;
    time_out_flag_d = time_out_flag_q;
    if (dec_sleep) begin
      power_down_flag_d = 1'b0;
      time_out_flag_d = 1'b1;
    end
  end

  // Direction registers: the instruction wins over a software write.
  always_comb begin
    dir_a_d = dir_a_q;
    dir_b_d = dir_b_q;
    if (sw_wr_a) begin
      dir_a_d = reg_wdata[PORT_A_W-1:0];
    end
    if (sw_wr_b) begin
      dir_b_d = reg_wdata[PORT_B_W-1:0];
    end
    if (dir_load_a) begin
      dir_a_d = w_q[PORT_A_W-1:0];
    end
    if (dir_load_b) begin
      dir_b_d = w_q[PORT_B_W-1:0];
    end
  end

  // Sequencer: returns spend a second cycle, sleep holds until wake.
  always_comb begin
    state_d = state_q;
    case (state_q)
      mix_pkg::MIX_ST_RUN: begin
        if (pop_op) begin
          state_d = mix_pkg::MIX_ST_DISCARD;
        end else if (dec_sleep) begin
          state_d = mix_pkg::MIX_ST_SLEEP;
        end
      end
      mix_pkg::MIX_ST_DISCARD: begin
        state_d = mix_pkg::MIX_ST_RUN;
      end
      mix_pkg::MIX_ST_SLEEP: begin
        if (wake) begin
          state_d = mix_pkg::MIX_ST_RUN;
        end
      end
      default: begin
        state_d = mix_pkg::MIX_ST_RUN;
      end
    endcase
  end

  // State and flag registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= mix_pkg::MIX_ST_RUN;
      w_q <= mix_pkg::WREG_RESET;
      carry_q <= 1'b0;
      dc_q <= 1'b0;
      zero_q <= 1'b0;
      power_down_flag_q <= 1'b1;
      time_out_flag_q <= 1'b1;
    end else begin
      state_q <= state_d;
      w_q <= w_d;
      carry_q <= carry_d;
      dc_q <= dc_d;
      zero_q <= zero_d;
      power_down_flag_q <= power_down_flag_d;
      time_out_flag_q <= time_out_flag_d;
    end
  end

  // Direction registers reset to all inputs.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_a_q <= mix_pkg::DIR_RESET[PORT_A_W-1:0];
      dir_b_q <= mix_pkg::DIR_RESET[PORT_B_W-1:0];
    end else begin
      dir_a_q <= dir_a_d;
      dir_b_q <= dir_b_d;
    end
  end

  // File write-back, registered one cycle after execution.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      file_we_q <= 1'b0;
      file_waddr_q <= 7'h00;
      file_wdata_q <= 8'h00;
    end else begin
      file_we_q <= to_file;
      file_waddr_q <= instr[mix_pkg::FADDR_LSB +: mix_pkg::FADDR_W];
      file_wdata_q <= alu_res;
    end
  end

  // Program counter load from the popped stack top.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_load_q <= 1'b0;
      pc_value_q <= 13'h0000;
    end else begin
      pc_load_q <= pop_op;
      pc_value_q <= pop_op ? stack_top : pc_value_q;
    end
  end

  // Watchdog clear pulse and software read data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdog_clear_q <= 1'b0;
      reg_rdata_q <= 8'h00;
    end else begin
      watchdog_clear_q <= dec_sleep;
      reg_rdata_q <= reg_re ? rd_mux : 8'h00;
    end
  end

  // Combinational file read address for same-cycle operand fetch.
  assign file_raddr = instr[mix_pkg::FADDR_LSB +: mix_pkg::FADDR_W];
  // Stack pop and fetch discard are handshake pulses in the executing cycle.
  assign stack_pop = pop_op;
  assign fetch_discard = pop_op;
  // Sleep request stays high while the core sleeps, stopping the oscillator.
  assign sleep_req = (state_q == mix_pkg::MIX_ST_SLEEP);
  assign busy = (state_q != mix_pkg::MIX_ST_RUN);
  // Output drivers are enabled where the direction bit is zero.
  assign port_a_oe = ~dir_a_q;
  assign port_b_oe = ~dir_b_q;
  assign file_we = file_we_q;
  assign file_waddr = file_waddr_q;
  assign file_wdata = file_wdata_q;
  assign pc_load = pc_load_q;
  assign pc_value = pc_value_q;
  assign watchdog_clear = watchdog_clear_q;
  assign w_out = w_q;
  assign reg_rdata = reg_rdata_q;
endmodule

// File: hw/mix_alu.sv
// Arithmetic unit for subtract, exclusive OR, rotate and nibble swap.
module mix_alu (
  input wire mix_pkg::mix_op_e op,
  input wire logic [7:0] a,
  input wire logic [7:0] w,
  input wire logic carry_in,
  output logic [7:0] result,
  output logic carry_out,
  output logic dc_out,
  output logic zero_out,
  output logic upd_c,
  output logic upd_dc,
  output logic upd_z
);
  // Nine-bit difference; the top bit is the borrow.
  wire [8:0] diff = {1'b0, a} - {1'b0, w};
  wire [4:0] ndiff = {1'b0, a[3:0]} - {1'b0, w[3:0]};

  // Result and flag selection per operation.
  always_comb begin
    result = a;
    carry_out = carry_in;
    dc_out = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    case (op)
      mix_pkg::MIX_OP_SUB: begin
        result = diff[7:0];
        carry_out = ~diff[8];
        dc_out = ~ndiff[4];
        upd_c = 1'b1;
        upd_dc = 1'b1;
        upd_z = 1'b1;
      end
      mix_pkg::MIX_OP_XOR: begin
        result = a ^ w;
        upd_z = 1'b1;
      end
      mix_pkg::MIX_OP_RL: begin
        result = {a[6:0], carry_in};
        carry_out = a[7];
        upd_c = 1'b1;
      end
      mix_pkg::MIX_OP_RR: begin
        result = {carry_in, a[7:1]};
        carry_out = a[0];
        upd_c = 1'b1;
      end
      mix_pkg::MIX_OP_SWAP: begin
        result = {a[3:0], a[7:4]};
      end
      default: begin
        result = a;
      end
    endcase
  end

  // Zero flag reflects the selected result.
  assign zero_out = (result == 8'h00);
endmodule

// File: test/mix_core_chk.sv
// Concurrent checks on the ports of the instruction decode and execute block.
module mix_core_chk #(
  parameter int PORT_A_W = 5,
  parameter int PORT_B_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  input wire logic [12:0] stack_top,
  input wire logic wake,
  input wire logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] file_wdata,
  input wire logic pc_load,
  input wire logic [12:0] pc_value,
  input wire logic stack_pop,
  input wire logic fetch_discard,
  input wire logic sleep_req,
  input wire logic watchdog_clear,
  input wire logic busy,
  input wire logic [7:0] w_out,
  input wire logic [PORT_B_W-1:0] port_b_oe,
  input wire logic reg_re,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // All checks share the one clock and reset.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // An instruction is taken only while the sequencer is free.
  wire go = instr_valid && !busy;
  a_ret_lit_w: assert property (go && instr[13:10] == 4'hd |=> w_out == $past(instr[7:0]) && pc_load)
    else $error("return with literal did not load the working register");
  a_pop_reload: assert property (stack_pop |=> pc_load && busy && pc_value == $past(stack_top) ##1 !busy)
    else $error("return did not reload the program counter over two cycles");
  a_pop_discard: assert property (stack_pop |-> fetch_discard)
    else $error("return did not discard the fetched word");
  a_sub_lit_w: assert property (go && instr[13:9] == 5'h1e |=> w_out == $past(instr[7:0]) - $past(w_out))
    else $error("literal minus working register is wrong");
  a_xor_lit_w: assert property (go && instr[13:8] == 6'h3a |=> w_out == ($past(w_out) ^ $past(instr[7:0])))
    else $error("literal exclusive OR is wrong");
  a_xor_file_dest: assert property (go && instr[13:8] == 6'h06 && instr[7] |=>
      file_we && file_waddr == $past(instr[6:0]) && file_wdata == ($past(w_out) ^ $past(file_rdata)))
    else $error("file exclusive OR not written back");
  a_dest_w_only: assert property (go && instr[13:8] == 6'h06 && !instr[7] |=> !file_we)
    else $error("file written although destination is the working register");
  a_sleep_enter: assert property (go && instr == 14'h0063 |=> sleep_req && watchdog_clear && busy)
    else $error("sleep entry incomplete");
  a_sleep_hold: assert property (sleep_req && !wake |=> sleep_req)
    else $error("sleep left without wake");
  a_sleep_wake: assert property (sleep_req && wake |=> !sleep_req)
    else $error("sleep not left on wake");
  a_dir_b_load: assert property (go && instr == 14'h0066 |=> port_b_oe == ~$past(w_out[PORT_B_W-1:0]))
    else $error("direction load of port six wrong");
  a_rdata_idle: assert property (!reg_re |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
endmodule

// File: test/mix_core_bench.sv
// Self-checking bench for the instruction decode and execute block.
module mix_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] instr = 14'h0000;
  logic instr_valid = 1'b0;
  logic [12:0] stack_top = 13'h0000;
  logic wake = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] file_rdata, file_wdata, w_out, reg_rdata, port_b_oe;
  logic [6:0] file_raddr, file_waddr;
  logic file_we, pc_load, stack_pop, fetch_discard, sleep_req, watchdog_clear, busy;
  logic [12:0] pc_value;
  logic [4:0] port_a_oe;
  // File register array standing in for the data memory.
  logic [7:0] fmem [128];
  int failures = 0;
  int cmp_count = 0;
  int wdc = 0;
  assign file_rdata = fmem[file_raddr];
  // Captures file writes and counts watchdog clear pulses.
  always @(posedge clk) begin
    if (file_we) fmem[file_waddr] <= file_wdata;
    if (watchdog_clear) wdc <= wdc + 1;
  end
  mix_core dut (.clk(clk), .rst(rst), .instr(instr), .instr_valid(instr_valid), .stack_top(stack_top),
    .wake(wake), .file_rdata(file_rdata), .file_raddr(file_raddr), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .pc_load(pc_load), .pc_value(pc_value), .stack_pop(stack_pop),
    .fetch_discard(fetch_discard), .sleep_req(sleep_req), .watchdog_clear(watchdog_clear), .busy(busy),
    .w_out(w_out), .port_a_oe(port_a_oe), .port_b_oe(port_b_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
  // Clock of 20 ns period.
  initial forever #10 clk = ~clk;
  // Prints the verdict and ends the run.
  task close_out;
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask
  // Presents one instruction for one edge.
  task ex(input logic [13:0] i);
    @(posedge clk);
    instr <= i;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask
  // Register port write, one strobe cycle.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  // Register port read; data stands only in the following cycle.
  task rc(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk(n, 16'(reg_rdata), 16'(e));
  endtask
  // Loads W, runs one instruction, checks W and status.
  task tw(input logic [7:0] w, input logic [13:0] i, input logic [7:0] ew, input logic [7:0] est);
    wr(8'h7f, w);
    ex(i);
    rc("w", 8'h7f, ew);
    rc("status", 8'h03, est);
  endtask
  // Hang guard, far beyond the some 170 cycles of the tests.
  initial begin
    #50us;
    failures++;
    close_out;
  end
  initial begin
    for (int k = 0; k < 128; k++) fmem[k] = 8'h00;
    fmem[8'h21] = 8'h3c;
    fmem[8'h22] = 8'h81;
    fmem[8'h23] = 8'ha5;
    fmem[8'h24] = 8'h0f;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped address.
    rc("status", 8'h03, 8'h18);
    rc("w", 8'h7f, 8'h00);
    rc("dir a", 8'h85, 8'h1f);
    rc("dir b", 8'h86, 8'hff);
    rc("unmapped", 8'h40, 8'h00);
    // Subtract literal: positive, negative with don't-care bit set, zero; then XOR literal into W.
    tw(8'h01, 14'h3c02, 8'h01, 8'h1b);
    tw(8'h02, 14'h3d01, 8'hff, 8'h18);
    tw(8'h05, 14'h3c05, 8'h00, 8'h1f);
    tw(8'h00, 14'h3a0f, 8'h0f, 8'h1b);
    // Subtract from file with wrap, written back to the file; XOR file into W and into the file.
    tw(8'h01, 14'h02a0, 8'h01, 8'h18);
    chk("file 20", 16'(fmem[8'h20]), 16'h00ff);
    tw(8'h3c, 14'h0621, 8'h00, 8'h1c);
    chk("file 21", 16'(fmem[8'h21]), 16'h003c);
    tw(8'hf0, 14'h06a4, 8'hf0, 8'h18);
    chk("file 24", 16'(fmem[8'h24]), 16'h00ff);
    // Rotates through carry; Z set beforehand must survive.
    tw(8'h3c, 14'h0621, 8'h00, 8'h1c);
    tw(8'h00, 14'h0da2, 8'h00, 8'h1d);
    chk("file 22", 16'(fmem[8'h22]), 16'h0002);
    tw(8'h00, 14'h0c22, 8'h81, 8'h1c);
    // Nibble swap to W and back to the file.
    tw(8'h00, 14'h0e23, 8'h5a, 8'h1c);
    tw(8'h11, 14'h0ea3, 8'h11, 8'h1c);
    chk("file 23", 16'(fmem[8'h23]), 16'h005a);
    // Direction loads, an invalid port and a direct write.
    tw(8'h0f, 14'h0066, 8'h0f, 8'h1c);
    chk("oe b", 16'(port_b_oe), 16'h00f0);
    tw(8'h03, 14'h0065, 8'h03, 8'h1c);
    chk("oe a", 16'(port_a_oe), 16'h001c);
    rc("dir a", 8'h85, 8'h03);
    tw(8'h00, 14'h0067, 8'h00, 8'h1c);
    rc("dir b", 8'h86, 8'h0f);
    wr(8'h86, 8'haa);
    rc("dir b", 8'h86, 8'haa);
    chk("oe b", 16'(port_b_oe), 16'h0055);
    // Return with literal, followed at once by a word that must be dropped.
    @(posedge clk);
    stack_top <= 13'h1abc;
    instr <= 14'h3477;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr <= 14'h3aff;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1 chk("pc", 16'(pc_value), 16'h1abc);
    rc("w", 8'h7f, 8'h77);
    rc("status", 8'h03, 8'h1c);
    // Plain return.
    @(posedge clk);
    stack_top <= 13'h0123;
    ex(14'h0008);
    #1 chk("pc", 16'(pc_value), 16'h0123);
    rc("w", 8'h7f, 8'h77);
    // Sleep, a refused word, then wake.
    ex(14'h0063);
    #1 chk("sleep", 16'(sleep_req), 16'h0001);
    rc("status", 8'h03, 8'h14);
    chk("wdt clear", 16'(wdc), 16'h0001);
    ex(14'h3aff);
    rc("w", 8'h7f, 8'h77);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    #1 chk("sleep", 16'(sleep_req), 16'h0000);
    ex(14'h3aff);
    rc("w", 8'h7f, 8'h88);
    close_out;
  end
endmodule
bind mix_core mix_core_chk #(.PORT_A_W(PORT_A_W), .PORT_B_W(PORT_B_W)) chk (.clk(clk), .rst(rst), .instr(instr),
  .instr_valid(instr_valid), .stack_top(stack_top), .wake(wake), .file_rdata(file_rdata), .file_we(file_we),
  .file_waddr(file_waddr), .file_wdata(file_wdata), .pc_load(pc_load), .pc_value(pc_value),
  .stack_pop(stack_pop), .fetch_discard(fetch_discard), .sleep_req(sleep_req),
  .watchdog_clear(watchdog_clear), .busy(busy), .w_out(w_out), .port_b_oe(port_b_oe), .reg_re(reg_re),
  .reg_rdata(reg_rdata));
